// >>> ssbs_pkg.sv
// Constants, types and register map of the servo stop and brake sequencer
// Contract
// - Travel limit while running applies stop method
// - Code 0: shorting brake, then coast
// - Code 1: coast to rest, then coast
// - Codes 2,3: plug brake, then coast
// - Codes 4,5: plug brake, then zero hold
// - Zero hold closes loop on zero reference
// - Stop mode sampled only at power-up
// - Plug torque limit 0..300, default 300, immediate
// - Torque setting in 1% of rated steps
// - Brake output unassigned in factory map
// - Digit holding 4 routes brake to terminal
// - Output map digit codes 0..8 decoded
// - Default timing: brake changes with disable
// - Signed servo-on wait -2000..2000 ms
// - Basic wait 0..500 x 10 ms
// - Alarm disables drive ignoring waits
// - Brake speed 10..100 rpm, wait 10..100 x 10 ms
// - Brake applied on slow speed or timeout
package ssbs_pkg;
   // ********************************
   // Timing
   // ********************************
   localparam int CLK_PERIOD_NS = 20;
   localparam int TICK_PERIOD_NS = 1000000;
   localparam int TICK_CYCLES = TICK_PERIOD_NS / CLK_PERIOD_NS;
   localparam int TEN_MS = 10;
   // ********************************
   // Register map and reset values
   // ********************************
   localparam logic [7:0] REG_PLUG_TORQUE = 8'h00;
   localparam logic [7:0] REG_ON_WAIT = 8'h04;
   localparam logic [7:0] REG_BASIC_WAIT = 8'h08;
   localparam logic [7:0] REG_BRK_SPEED = 8'h0C;
   localparam logic [7:0] REG_BRK_WAIT = 8'h10;
   localparam logic [7:0] REG_OUT_MAP = 8'h14;
   localparam logic [7:0] REG_STATUS = 8'h18;
   localparam logic [8:0] PLUG_TORQUE_RST = 9'h12C;
   localparam logic [8:0] PLUG_TORQUE_MAX = 9'h12C;
   localparam logic signed [11:0] ON_WAIT_RST = 12'sh000;
   localparam logic signed [11:0] ON_WAIT_MAX = 12'sh7D0;
   localparam logic signed [11:0] ON_WAIT_MIN = -12'sh7D0;
   localparam logic [8:0] BASIC_WAIT_RST = 9'h000;
   localparam logic [8:0] BASIC_WAIT_MAX = 9'h1F4;
   localparam logic [6:0] BRK_SPEED_RST = 7'h64;
   localparam logic [6:0] BRK_WAIT_RST = 7'h32;
   localparam logic [6:0] BRK_LIM_MIN = 7'h0A;
   localparam logic [6:0] BRK_LIM_MAX = 7'h64;
   localparam logic [11:0] OUT_MAP_RST = 12'h210;
   // Field positions of the status word
   localparam int ST_STATE_LSB = 0;
   localparam int ST_BRAKE_BIT = 4;
   localparam int ST_ENABLE_BIT = 5;
   localparam int ST_MODE_LSB = 8;
   // ********************************
   // Types
   // ********************************
   typedef enum logic [3:0]
   {
      FN_IN_POS = 4'h0, FN_SPIN = 4'h1, FN_READY = 4'h2, FN_TORQUE_LIM = 4'h3, FN_BRAKE = 4'h4,
      FN_INDEX = 4'h5, FN_LIMIT = 4'h6, FN_EXCITE = 4'h7, FN_HOME = 4'h8
   } ssbs_func_e;
   typedef enum logic [2:0]
   {
      ACT_DRIVE = 3'h0, ACT_SHORT = 3'h1, ACT_COAST = 3'h2, ACT_PLUG = 3'h3, ACT_HOLD = 3'h4
   } ssbs_act_e;
   typedef struct packed
   {
      logic       in_position;
      logic       spin_detect;
      logic       drive_ready;
      logic       torque_limited;
      logic       index_pulse;
      logic       homing_done;
   } ssbs_flags_s;
   typedef struct packed
   {
      logic [7:0]  addr;
      logic [31:0] wdata;
      logic        wr;
      logic        rd;
   } ssbs_bus_s;
endpackage : ssbs_pkg

// >>> ssbs_top.sv
// Stop method and holding brake sequencer with register port
`timescale 1ns/100ps
module ssbs_top
#(
   parameter int TICK_LEN = ssbs_pkg::TICK_CYCLES
)
(
   input  wire logic                   clk_in,
   input  wire logic                   reset_in,
   input  wire ssbs_pkg::ssbs_bus_s    bus_in,
   output logic [31:0]                 rd_data_out,
   input  wire logic [3:0]             stop_mode_select_in,
   input  wire logic                   fwd_limit_switch_in,
   input  wire logic                   rev_limit_switch_in,
   input  wire logic                   servo_on_in,
   input  wire logic                   alarm_in,
   input  wire logic [15:0]            motor_speed_in,
   input  wire ssbs_pkg::ssbs_flags_s  flags_in,
   output ssbs_pkg::ssbs_act_e         stop_action_out,
   output logic [8:0]                  torque_limit_out,
   output logic                        zero_hold_out,
   output logic [31:0]                 pos_ref_out,
   output logic                        motor_enable_out,
   output logic                        brake_interlock_out,
   output logic [2:0]                  terminal_out
);
   import ssbs_pkg::*;

   // ********************************
   // Pin synchronisers
   // ********************************
   logic [4:0] sync1_r;
   logic [4:0] sync2_r;
   always_ff @(posedge clk_in)
   begin
      sync1_r <= {stop_mode_select_in[0], fwd_limit_switch_in, rev_limit_switch_in, servo_on_in, alarm_in};
      sync2_r <= sync1_r;
   end
   logic [2:0] mode_s1_r;
   logic [2:0] mode_s2_r;
   always_ff @(posedge clk_in)
   begin
      mode_s1_r <= stop_mode_select_in[3:1];
      mode_s2_r <= mode_s1_r;
   end
   wire logic [3:0] mode_pin = {mode_s2_r, sync2_r[4]};
   wire logic       limit_hit = sync2_r[3] | sync2_r[2];
   wire logic       on_req = sync2_r[1];
   wire logic       alarm = sync2_r[0];

   // ********************************
   // Stop mode capture at power-up
   // ********************************
   // Caught once after reset so later pin changes need a power cycle
   logic [3:0] mode_r;
   logic       mode_taken_r;
   logic [1:0] settle_r;
   always_ff @(posedge clk_in)
   begin
      if (reset_in)
      begin
         mode_r <= 4'h0;
         mode_taken_r <= 1'b0;
         settle_r <= 2'h0;
      end
      else if (!mode_taken_r)
      begin
         settle_r <= settle_r + 2'h1;
         if (settle_r == 2'h3)
         begin
            mode_r <= (mode_pin > 4'h5) ? 4'h0 : mode_pin;
            mode_taken_r <= 1'b1;
         end
      end
   end

   // ********************************
   // Registers
   // ********************************
   logic [8:0]         plug_torque_limit_r;
   logic signed [11:0] servo_on_wait_r;
   logic [8:0]         basic_wait_delay_r;
   logic [6:0]         brake_speed_threshold_r;
   logic [6:0]         brake_wait_time_r;
   logic [11:0]        output_function_map_r;
   wire logic signed [31:0] w_wait = signed'(bus_in.wdata);
   wire logic [6:0]         w_brk = (bus_in.wdata[31:7] != 25'h0) ? BRK_LIM_MAX : bus_in.wdata[6:0];
   wire logic [6:0]         w_brk_cl = w_brk < BRK_LIM_MIN ? BRK_LIM_MIN : w_brk > BRK_LIM_MAX ? BRK_LIM_MAX : w_brk;
   wire logic               wr_torque = bus_in.wr && bus_in.addr == REG_PLUG_TORQUE;
   wire logic               wr_on = bus_in.wr && bus_in.addr == REG_ON_WAIT;
   wire logic               wr_basic = bus_in.wr && bus_in.addr == REG_BASIC_WAIT;
   wire logic               wr_bspd = bus_in.wr && bus_in.addr == REG_BRK_SPEED;
   wire logic               wr_bwait = bus_in.wr && bus_in.addr == REG_BRK_WAIT;
   wire logic               wr_map = bus_in.wr && bus_in.addr == REG_OUT_MAP;
   always_ff @(posedge clk_in)
   begin
      if (reset_in)
      begin
         plug_torque_limit_r <= PLUG_TORQUE_RST;
         servo_on_wait_r <= ON_WAIT_RST;
         basic_wait_delay_r <= BASIC_WAIT_RST;
         brake_speed_threshold_r <= BRK_SPEED_RST;
         brake_wait_time_r <= BRK_WAIT_RST;
         output_function_map_r <= OUT_MAP_RST;
      end
      else
      begin
         if (wr_torque)
            plug_torque_limit_r <= (bus_in.wdata > 32'(PLUG_TORQUE_MAX)) ? PLUG_TORQUE_MAX : bus_in.wdata[8:0];
         if (wr_on)
            servo_on_wait_r <= (w_wait > 32'(ON_WAIT_MAX)) ? ON_WAIT_MAX :
                               ((w_wait < 32'(ON_WAIT_MIN)) ? ON_WAIT_MIN : w_wait[11:0]);
         if (wr_basic)
            basic_wait_delay_r <= (bus_in.wdata > 32'(BASIC_WAIT_MAX)) ? BASIC_WAIT_MAX : bus_in.wdata[8:0];
         if (wr_bspd)
            brake_speed_threshold_r <= w_brk_cl;
         if (wr_bwait)
            brake_wait_time_r <= w_brk_cl;
         if (wr_map)
            output_function_map_r <= bus_in.wdata[11:0];
      end
   end

   // ********************************
   // Millisecond tick and delay counter
   // ********************************
   logic [15:0] tick_cnt_r;
   wire logic   tick = (tick_cnt_r == 16'(TICK_LEN - 1));
   always_ff @(posedge clk_in)
   begin
      if (reset_in || tick)
         tick_cnt_r <= 16'h0000;
      else
         tick_cnt_r <= tick_cnt_r + 16'h0001;
   end

   // ********************************
   // Sequencer
   // ********************************
   typedef enum logic [2:0]
   {
      S_OFF = 3'b000, S_ON_WAIT = 3'b001, S_RUN = 3'b010, S_OFF_WAIT = 3'b011,
      S_SLOW_DOWN = 3'b100, S_LIMIT = 3'b101, S_HOLD = 3'b110
   } ssbs_state_e;
   ssbs_state_e state_r;
   ssbs_state_e state_nxt;
   ssbs_act_e   kind_r;
   ssbs_act_e   kind_nxt;
   ssbs_act_e   act_nxt;
   logic [12:0] dly_r;
   logic [12:0] dly_nxt;
   logic        brake_nxt;
   logic        en_nxt;

   wire logic        stopped = (motor_speed_in == 16'h0000);
   wire logic        slow = (motor_speed_in < {9'h000, brake_speed_threshold_r});
   wire logic        dly_done = (dly_r == 13'h0000);
   wire logic        wait_neg = servo_on_wait_r[11];
   wire logic [11:0] wait_abs = wait_neg ? 12'(-servo_on_wait_r) : servo_on_wait_r;
   wire ssbs_act_e   off_kind = mode_r[0] ? ACT_COAST : ACT_SHORT;
   wire logic        plug_mode = (mode_r >= 4'h2);
   wire logic        hold_mode = (mode_r >= 4'h4);
   wire logic        off_req = alarm || !on_req;

   always_comb
   begin
      state_nxt = state_r;
      kind_nxt = kind_r;
      dly_nxt = (tick && !dly_done) ? dly_r - 13'h0001 : dly_r;
      brake_nxt = brake_interlock_out;
      en_nxt = motor_enable_out;
      unique case (state_r)
         S_OFF:
         begin
            brake_nxt = 1'b1;
            en_nxt = 1'b0;
            kind_nxt = ACT_COAST;
            if (on_req && !alarm && mode_taken_r)
            begin
               if (wait_abs == 12'h000)
               begin
                  state_nxt = S_RUN;
                  brake_nxt = 1'b0;
                  en_nxt = 1'b1;
               end
               else
               begin
                  state_nxt = S_ON_WAIT;
                  dly_nxt = {1'b0, wait_abs};
                  brake_nxt = wait_neg;
                  en_nxt = wait_neg;
               end
            end
         end
         S_ON_WAIT:
         begin
            if (off_req)
            begin
               state_nxt = S_OFF;
               brake_nxt = 1'b1;
               en_nxt = 1'b0;
            end
            else if (dly_done)
            begin
               state_nxt = S_RUN;
               brake_nxt = 1'b0;
               en_nxt = 1'b1;
            end
         end
         S_OFF_WAIT:
         begin
            if (alarm || dly_done)
            begin
               state_nxt = S_OFF;
               en_nxt = 1'b0;
            end
         end
         S_SLOW_DOWN:
         begin
            if (slow || dly_done)
            begin
               state_nxt = S_OFF;
               brake_nxt = 1'b1;
            end
         end
         S_RUN, S_LIMIT, S_HOLD:
         begin
            if (off_req)
            begin
               kind_nxt = off_kind;
               if (!slow)
               begin
                  state_nxt = S_SLOW_DOWN;
                  dly_nxt = 13'(brake_wait_time_r * TEN_MS);
                  en_nxt = 1'b0;
               end
               else if (alarm || basic_wait_delay_r == 9'h000)
               begin
                  state_nxt = S_OFF;
                  brake_nxt = 1'b1;
                  en_nxt = 1'b0;
               end
               else
               begin
                  state_nxt = S_OFF_WAIT;
                  dly_nxt = 13'(basic_wait_delay_r * TEN_MS);
                  brake_nxt = 1'b1;
               end
            end
            else if (state_r == S_RUN)
            begin
               if (limit_hit && !stopped)
               begin
                  state_nxt = S_LIMIT;
                  kind_nxt = plug_mode ? ACT_PLUG : off_kind;
                  en_nxt = plug_mode;
               end
            end
            else if (!limit_hit)
            begin
               state_nxt = S_RUN;
               kind_nxt = ACT_DRIVE;
               en_nxt = 1'b1;
            end
            else if (state_r == S_LIMIT && stopped)
            begin
               if (hold_mode)
               begin
                  state_nxt = S_HOLD;
                  kind_nxt = ACT_HOLD;
                  en_nxt = 1'b1;
               end
               else
               begin
                  kind_nxt = ACT_COAST;
                  en_nxt = 1'b0;
               end
            end
         end
         default:
         begin
            state_nxt = S_OFF;
            brake_nxt = 1'b1;
            en_nxt = 1'b0;
         end
      endcase
      if (state_nxt == S_RUN || state_nxt == S_ON_WAIT)
         act_nxt = (state_nxt == S_RUN || wait_neg) ? ACT_DRIVE : ACT_COAST;
      else if (state_nxt == S_OFF_WAIT)
         act_nxt = ACT_DRIVE;
      else if (stopped && kind_nxt != ACT_HOLD)
         act_nxt = ACT_COAST;
      else
         act_nxt = kind_nxt;
   end

   always_ff @(posedge clk_in)
   begin
      if (reset_in)
      begin
         state_r <= S_OFF;
         kind_r <= ACT_COAST;
         dly_r <= 13'h0000;
         brake_interlock_out <= 1'b1;
         motor_enable_out <= 1'b0;
         stop_action_out <= ACT_COAST;
      end
      else
      begin
         state_r <= state_nxt;
         kind_r <= kind_nxt;
         dly_r <= dly_nxt;
         brake_interlock_out <= brake_nxt;
         motor_enable_out <= en_nxt;
         stop_action_out <= act_nxt;
      end
   end

   // ********************************
   // Torque ceiling, zero hold and terminals
   // ********************************
   // Percent of rated torque passes straight to the current loop
   wire logic [8:0] torque_nxt = (act_nxt == ACT_PLUG) ? plug_torque_limit_r : PLUG_TORQUE_MAX;
   wire logic       hold_nxt = (act_nxt == ACT_HOLD);
   logic [2:0] term_nxt;
   always_comb
   begin
      for (int i = 0; i < 3; i++)
      begin
         unique case (output_function_map_r[4*i +: 4])
            FN_IN_POS: term_nxt[i] = flags_in.in_position;
            FN_SPIN: term_nxt[i] = flags_in.spin_detect;
            FN_READY: term_nxt[i] = flags_in.drive_ready;
            FN_TORQUE_LIM: term_nxt[i] = flags_in.torque_limited;
            FN_BRAKE: term_nxt[i] = !brake_nxt;
            FN_INDEX: term_nxt[i] = flags_in.index_pulse;
            FN_LIMIT: term_nxt[i] = (state_nxt == S_LIMIT || state_nxt == S_HOLD);
            FN_EXCITE: term_nxt[i] = en_nxt;
            FN_HOME: term_nxt[i] = flags_in.homing_done;
            default: term_nxt[i] = 1'b0;
         endcase
      end
   end
   always_ff @(posedge clk_in)
   begin
      if (reset_in)
      begin
         torque_limit_out <= PLUG_TORQUE_RST;
         zero_hold_out <= 1'b0;
         pos_ref_out <= 32'h00000000;
         terminal_out <= 3'h0;
      end
      else
      begin
         torque_limit_out <= torque_nxt;
         zero_hold_out <= hold_nxt;
         pos_ref_out <= 32'h00000000;
         terminal_out <= term_nxt;
      end
   end

   // ********************************
   // Read port
   // ********************************
   logic [31:0] rd_mux;
   always_comb
   begin
      rd_mux = 32'h00000000;
      unique case (bus_in.addr)
         REG_PLUG_TORQUE: rd_mux = {23'h0, plug_torque_limit_r};
         REG_ON_WAIT: rd_mux = {{20{servo_on_wait_r[11]}}, servo_on_wait_r};
         REG_BASIC_WAIT: rd_mux = {23'h0, basic_wait_delay_r};
         REG_BRK_SPEED: rd_mux = {25'h0, brake_speed_threshold_r};
         REG_BRK_WAIT: rd_mux = {25'h0, brake_wait_time_r};
         REG_OUT_MAP: rd_mux = {20'h0, output_function_map_r};
         REG_STATUS:
         begin
            rd_mux[ST_STATE_LSB +: 3] = state_r;
            rd_mux[ST_BRAKE_BIT] = brake_interlock_out;
            rd_mux[ST_ENABLE_BIT] = motor_enable_out;
            rd_mux[ST_MODE_LSB +: 4] = mode_r;
         end
         default: rd_mux = 32'h00000000;
      endcase
   end
   always_ff @(posedge clk_in)
   begin
      if (reset_in || !bus_in.rd)
         rd_data_out <= 32'h00000000;
      else
         rd_data_out <= rd_mux;
   end
endmodule : ssbs_top

// >>> ssbs_checker.sv
// Port checker for the stop and brake sequencer
`timescale 1ns/100ps
module ssbs_checker
#(
   parameter int TICK_LEN = ssbs_pkg::TICK_CYCLES
)
(
   input wire logic                  clk_in,
   input wire logic                  reset_in,
   input wire ssbs_pkg::ssbs_bus_s   bus_in,
   input wire logic                  fwd_limit_switch_in,
   input wire logic                  rev_limit_switch_in,
   input wire logic                  servo_on_in,
   input wire logic                  alarm_in,
   input wire logic [15:0]           motor_speed_in,
   input wire ssbs_pkg::ssbs_act_e   stop_action_out,
   input wire logic [8:0]            torque_limit_out,
   input wire logic                  zero_hold_out,
   input wire logic [31:0]           pos_ref_out,
   input wire logic                  motor_enable_out,
   input wire logic                  brake_interlock_out,
   input wire logic [2:0]            terminal_out
);
   import ssbs_pkg::*;
   // ****************************************
   // Output map shadow and properties
   // ****************************************
   logic [11:0] map_r;
   logic [1:0]  quiet_r;
   wire         map_wr = bus_in.wr && bus_in.addr == REG_OUT_MAP;
   // Terminal lags a map write, so the map check waits until it has settled
   always_ff @(posedge clk_in)
   begin
      map_r <= reset_in ? OUT_MAP_RST : (map_wr ? bus_in.wdata[11:0] : map_r);
      quiet_r <= (reset_in || map_wr) ? 2'h0 : (quiet_r == 2'h3 ? quiet_r : quiet_r + 2'h1);
   end
   default clocking @(posedge clk_in); endclocking
   default disable iff (reset_in);
   sequence s_alarm_held;
      alarm_in [*4];
   endsequence
   sequence s_quiet_stop;
      (!servo_on_in && !fwd_limit_switch_in && !rev_limit_switch_in && motor_speed_in < 16'h000A) [*8];
   endsequence
   property p_reset;
      $past(reset_in) |-> brake_interlock_out && !motor_enable_out && terminal_out == 3'h0;
   endproperty
   property p_alarm;
      s_alarm_held |=> !motor_enable_out;
   endproperty
   property p_slow_brake;
      s_quiet_stop |=> brake_interlock_out;
   endproperty
   property p_map;
      (quiet_r == 2'h3 && map_r[3:0] == 4'h4 && brake_interlock_out == $past(brake_interlock_out, 2))
         |-> terminal_out[0] == !brake_interlock_out;
   endproperty
   property p_torque_idle;
      (stop_action_out != ACT_PLUG && $past(stop_action_out) != ACT_PLUG) |-> torque_limit_out == PLUG_TORQUE_RST;
   endproperty
   property p_torque_max;
      torque_limit_out <= PLUG_TORQUE_MAX;
   endproperty
   property p_plug_on;
      stop_action_out == ACT_PLUG |-> motor_enable_out;
   endproperty
   property p_short_off;
      stop_action_out == ACT_SHORT |-> !motor_enable_out;
   endproperty
   property p_hold;
      zero_hold_out |-> stop_action_out == ACT_HOLD && pos_ref_out == 32'h0 && motor_enable_out;
   endproperty
   property p_hold_flag;
      stop_action_out == ACT_HOLD |-> zero_hold_out;
   endproperty
   a_reset: assert property (p_reset) else $error("outputs wrong after reset");
   a_alarm: assert property (p_alarm) else $error("motor powered during alarm");
   a_slow_brake: assert property (p_slow_brake) else $error("brake open at standstill");
   a_map: assert property (p_map) else $error("first pair does not follow brake");
   a_torque_idle: assert property (p_torque_idle) else $error("ceiling not full outside plug");
   a_torque_max: assert property (p_torque_max) else $error("ceiling above range");
   a_plug_on: assert property (p_plug_on) else $error("plug braking unpowered");
   a_short_off: assert property (p_short_off) else $error("shorting while powered");
   a_hold: assert property (p_hold) else $error("hold without zero reference");
   a_hold_flag: assert property (p_hold_flag) else $error("hold flag missing");
endmodule : ssbs_checker
bind ssbs_top ssbs_checker #(.TICK_LEN(TICK_LEN)) ssbs_checker_inst
(
   .clk_in, .reset_in, .bus_in, .fwd_limit_switch_in, .rev_limit_switch_in, .servo_on_in, .alarm_in,
   .motor_speed_in, .stop_action_out, .torque_limit_out, .zero_hold_out, .pos_ref_out, .motor_enable_out,
   .brake_interlock_out, .terminal_out
);

// >>> ssbs_partner.sv
// Motor, brake relay and limit switch model beside the sequencer
`timescale 1ns/100ps
module ssbs_partner
(
   input  wire logic                 clk_in,
   input  wire ssbs_pkg::ssbs_act_e  stop_action_in,
   input  wire logic                 motor_enable_in,
   input  wire logic                 brake_in,
   input  wire logic [15:0]          speed_set_in,
   input  wire logic                 fwd_req_in,
   input  wire logic                 rev_req_in,
   output logic [15:0]               motor_speed_out,
   output logic                      fwd_limit_switch_out,
   output logic                      rev_limit_switch_out
);
   import ssbs_pkg::*;
   // ****************************************
   // Shaft speed
   // ****************************************
   // Coasting only loses speed to friction, every braked stop is far quicker
   wire logic [15:0] step_w = (stop_action_in == ACT_COAST) ? 16'h0001 : 16'h0032;
   initial motor_speed_out = 16'h0000;
   always @(posedge clk_in)
   begin
      if (motor_enable_in && !brake_in && stop_action_in == ACT_DRIVE)
         motor_speed_out <= speed_set_in;
      else
         motor_speed_out <= (motor_speed_out > step_w) ? motor_speed_out - step_w : 16'h0000;
   end
   assign fwd_limit_switch_out = fwd_req_in;
   assign rev_limit_switch_out = rev_req_in;
endmodule : ssbs_partner

// >>> ssbs_bench.sv
// Self-checking bench for the stop and brake sequencer
`timescale 1ns/100ps
module ssbs_bench;
   import ssbs_pkg::*;
   // ****************************************
   // Signals, tables and instances
   // ****************************************
   localparam int TK = 10;
   logic        clk_in = 1'b0;
   logic        reset_in = 1'b1;
   ssbs_bus_s   bus_in = '0;
   logic [3:0]  mode = 4'h0;
   logic        srv = 1'b0;
   logic        alm = 1'b0;
   logic        fwd = 1'b0;
   logic        rev = 1'b0;
   logic [15:0] spd_set = 16'h0000;
   ssbs_flags_s flags = '0;
   logic [31:0] rdat, pref;
   ssbs_act_e   act;
   logic [8:0]  tq;
   logic [2:0]  term;
   logic [15:0] spd;
   logic        hold, en, brk, fls, rls;
   int          n_mismatch = 0;
   int          checks = 0;
   int          cyc = 0;
   int          n;
   logic [31:0] rv [7] = '{32'h12C, 32'h0, 32'h0, 32'h64, 32'h32, 32'h210, 32'h0};
   logic [31:0] wv [5] = '{32'h190, 32'hBB8, 32'h258, 32'h5, 32'hFF};
   logic [31:0] ev [5] = '{32'h12C, 32'h7D0, 32'h1F4, 32'hA, 32'h64};
   logic [3:0]  fc [6] = '{4'h0, 4'h1, 4'h2, 4'h3, 4'h5, 4'h8};
   ssbs_top #(.TICK_LEN(TK)) ssbs_top_inst
   (
      .clk_in(clk_in), .reset_in(reset_in), .bus_in(bus_in), .rd_data_out(rdat), .stop_mode_select_in(mode),
      .fwd_limit_switch_in(fls), .rev_limit_switch_in(rls), .servo_on_in(srv), .alarm_in(alm),
      .motor_speed_in(spd), .flags_in(flags), .stop_action_out(act), .torque_limit_out(tq), .zero_hold_out(hold),
      .pos_ref_out(pref), .motor_enable_out(en), .brake_interlock_out(brk), .terminal_out(term)
   );
   ssbs_partner ssbs_partner_inst
   (
      .clk_in(clk_in), .stop_action_in(act), .motor_enable_in(en), .brake_in(brk), .speed_set_in(spd_set),
      .fwd_req_in(fwd), .rev_req_in(rev), .motor_speed_out(spd), .fwd_limit_switch_out(fls),
      .rev_limit_switch_out(rls)
   );
   initial forever #10 clk_in = ~clk_in;
   // Whole run needs about 8000 cycles
   always @(posedge clk_in)
   begin
      cyc++;
      if (cyc == 40000)
      begin
         n_mismatch++;
         finish_test();
      end
   end
   task automatic finish_test;
      $display("comparisons %0d mismatches %0d", checks, n_mismatch);
      if (n_mismatch == 0 && checks > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask : finish_test
   task automatic cmp(input string nm, input logic [31:0] e, input logic [31:0] g);
      checks++;
      if (g !== e)
      begin
         n_mismatch++;
         $display("mismatch %s expected %0h seen %0h", nm, e, g);
      end
   endtask : cmp
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      bus_in.addr <= a;
      bus_in.wdata <= d;
      bus_in.wr <= 1'b1;
      @(posedge clk_in);
      bus_in.wr <= 1'b0;
      @(posedge clk_in);
   endtask : wr
   task automatic rdc(input logic [7:0] a, input logic [31:0] e, input logic [31:0] m);
      bus_in.addr <= a;
      bus_in.rd <= 1'b1;
      @(posedge clk_in);
      bus_in.rd <= 1'b0;
      @(posedge clk_in);
      cmp("read data", e, rdat & m);
   endtask : rdc
   // Bounded wait on enable or brake, then compare the level reached
   task automatic wt(input bit sel_en, input logic val, input int lim);
      n = 0;
      while ((sel_en ? en : brk) !== val && n < lim)
      begin
         @(posedge clk_in);
         n++;
      end
      cmp(sel_en ? "enable" : "brake", {31'h0, val}, {31'h0, sel_en ? en : brk});
   endtask : wt
   task automatic rst(input logic [3:0] m);
      mode <= m;
      reset_in <= 1'b1;
      repeat (4) @(posedge clk_in);
      reset_in <= 1'b0;
      repeat (6) @(posedge clk_in);
   endtask : rst
   // ****************************************
   // Tests
   // ****************************************
   initial
   begin
      rst(4'h0);
      cmp("brake", 32'h1, brk);
      cmp("torque", 32'h12C, tq);
      for (int i = 0; i < 7; i++)
         rdc(i == 6 ? 8'h1C : 8'(4 * i), rv[i], 32'hFFFFFFFF);
      for (int i = 0; i < 5; i++)
      begin
         wr(8'(4 * i), wv[i]);
         rdc(8'(4 * i), ev[i], 32'hFFF);
      end
      wr(REG_STATUS, 32'hFFFFFFFF);
      rdc(REG_STATUS, 32'h0, 32'hF00);
      for (int i = 0; i < 6; i++)
      begin
         wr(REG_OUT_MAP, {20'h0, 8'h67, fc[i]});
         flags <= ssbs_flags_s'(6'h20 >> i);
         repeat (3) @(posedge clk_in);
         cmp("terminal", 32'h1, term);
         flags <= '0;
         repeat (3) @(posedge clk_in);
         cmp("terminal", 32'h0, term);
      end
      $display("registers test done");
      for (int m = 0; m < 6; m++)
      begin
         rst(m[3:0]);
         mode <= 4'h5 - m[3:0];
         wr(REG_PLUG_TORQUE, 32'h96);
         spd_set <= 16'h0BB8;
         srv <= 1'b1;
         wt(1, 1, 20);
         cmp("brake", 32'h0, brk);
         fwd <= !m[0];
         rev <= m[0];
         repeat (8) @(posedge clk_in);
         cmp("action", m == 0 ? ACT_SHORT : (m == 1 ? ACT_COAST : ACT_PLUG), act);
         cmp("torque", m > 1 ? 32'h96 : 32'h12C, tq);
         repeat (3200) if (spd != 16'h0) @(posedge clk_in);
         repeat (4) @(posedge clk_in);
         cmp("action", m > 3 ? ACT_HOLD : ACT_COAST, act);
         cmp("hold", {31'h0, m > 3}, hold);
         cmp("position", 32'h0, pref);
         cmp("enable", {31'h0, m > 3}, en);
         rdc(REG_STATUS, 32'(m) << 8, 32'hF00);
         fwd <= 1'b0;
         rev <= 1'b0;
         srv <= 1'b0;
      end
      $display("stop mode test done");
      rst(4'h1);
      spd_set <= 16'h0BB8;
      srv <= 1'b1;
      wt(1, 1, 20);
      for (int i = 0; i < 3; i++)
      begin
         wr(REG_OUT_MAP, 32'h4 << (4 * i));
         repeat (3) @(posedge clk_in);
         cmp("terminal", 32'h1 << i, term);
      end
      wr(REG_OUT_MAP, 32'h004);
      wr(REG_BRK_WAIT, 32'h0A);
      srv <= 1'b0;
      wt(1, 0, 6);
      cmp("action", ACT_COAST, act);
      wt(0, 1, 1010);
      cmp("brake wait", 32'h1, n > 980);
      repeat (2) @(posedge clk_in);
      cmp("terminal", 32'h0, term);
      wr(REG_BRK_WAIT, 32'h64);
      srv <= 1'b1;
      wt(1, 1, 20);
      repeat (3) @(posedge clk_in);
      srv <= 1'b0;
      wt(0, 1, 3100);
      cmp("speed at brake", 32'h1, spd < 16'd100 && spd > 16'd94);
      $display("brake timing test done");
      spd_set <= 16'h0000;
      wr(REG_ON_WAIT, 32'h14);
      srv <= 1'b1;
      wt(0, 0, 10);
      wt(1, 1, 210);
      cmp("on wait", 32'h1, n > 186);
      srv <= 1'b0;
      wt(1, 0, 10);
      cmp("brake", 32'h1, brk);
      repeat (4) @(posedge clk_in);
      wr(REG_ON_WAIT, 32'hFFFFFFEC);
      srv <= 1'b1;
      wt(1, 1, 10);
      wt(0, 0, 210);
      cmp("on wait", 32'h1, n > 186);
      wr(REG_ON_WAIT, 32'h0);
      wr(REG_BASIC_WAIT, 32'h5);
      srv <= 1'b0;
      wt(0, 1, 10);
      repeat (100) @(posedge clk_in);
      cmp("enable", 32'h1, en);
      alm <= 1'b1;
      wt(1, 0, 5);
      alm <= 1'b0;
      $display("servo wait test done");
      finish_test();
   end
endmodule : ssbs_bench
